// ===== rtl/dcm_dc_measure.sv
`timescale 1ns/1ps
`default_nettype none

module dcm_dc_measure
  import dcm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic modValid,
  input wire logic modBit,
  input wire dcm_reg_req_type regReq,
  output logic [7:0] regRdData
);

  dcm_state_type state_reg;
  dcm_state_type state_next;

  function automatic logic windowEnd(input logic [20:0] cnt,
                                     input logic [4:0] code);
    windowEnd = (cnt == ((21'h000001 << code) - 21'h000001));
  endfunction : windowEnd

  logic enable;
  logic iirMode;
  logic freeze;
  logic reportLatched;
  logic [4:0] dSet;
  logic [4:0] avgCode;
  logic signed [23:0] modSample;
  logic signed [24:0] iirDiff;
  logic signed [24:0] iirStep;
  logic signed [23:0] iirOut;
  logic signed [23:0] sincSum;
  logic sincEnd;
  logic iirEnd;

  assign enable = state_reg.cfg_reg[DCM_ENABLE_BIT];
  assign iirMode = state_reg.cfg_reg[DCM_METHOD_BIT];
  assign dSet = state_reg.cfg_reg[4:0];
  assign freeze = state_reg.iirCfg_reg[DCM_FREEZE_BIT];
  assign reportLatched = state_reg.iirCfg_reg[DCM_REPORT_BIT];
  assign avgCode = state_reg.iirCfg_reg[4:0];
  assign regRdData = state_reg.rdData_reg;

  assign modSample = modBit ? DCM_IIR_POS : DCM_IIR_NEG;
  assign iirDiff = {modSample[23], modSample} -
                   {state_reg.acc_reg[23], state_reg.acc_reg};
  assign iirStep = iirDiff >>> dSet;
  assign iirOut = state_reg.acc_reg + iirStep[23:0];
  assign sincSum = state_reg.acc_reg + (modBit ? 24'sh000001 : 24'shFFFFFF);
  assign sincEnd = windowEnd(state_reg.sincCnt_reg, dSet);
  // Code zero never clears: infinite averaging
  assign iirEnd = (avgCode != 5'h00) &&
                  windowEnd(state_reg.iirCnt_reg, avgCode);

  always_comb begin
    state_next = state_reg;
    // Registered readback keeps the data output off the decode path
    unique case (regReq.addr)
      DCM_CFG_OFS: state_next.rdData_reg = state_reg.cfg_reg;
      DCM_IIR_OFS: state_next.rdData_reg = state_reg.iirCfg_reg;
      DCM_RES_HI_OFS:
        state_next.rdData_reg = state_reg.result_reg[23:16];
      DCM_RES_MID_OFS:
        state_next.rdData_reg = state_reg.result_reg[15:8];
      DCM_RES_LO_OFS: state_next.rdData_reg = state_reg.result_reg[7:0];
      default: state_next.rdData_reg = 8'h00;
    endcase
    if (enable && modValid) begin
      if (!iirMode) begin
        state_next.sincCnt_reg = state_reg.sincCnt_reg + 21'h000001;
        state_next.acc_reg = sincSum;
        if (sincEnd) begin
          state_next.sincCnt_reg = DCM_CNT_RESET;
          state_next.acc_reg = 24'sh000000;
          if (!freeze) begin
            state_next.result_reg = sincSum;
          end
        end
      end else begin
        state_next.acc_reg = iirOut;
        state_next.iirCnt_reg = state_reg.iirCnt_reg + 21'h000001;
        if (!freeze && !reportLatched) begin
          state_next.result_reg = iirOut;
        end
        if (iirEnd) begin
          state_next.iirCnt_reg = DCM_CNT_RESET;
          state_next.acc_reg = 24'sh000000;
          if (!freeze && reportLatched) begin
            state_next.result_reg = iirOut;
          end
        end
      end
    end else if (!enable) begin
      // Filter restarts clean; result keeps its last value
      state_next.acc_reg = 24'sh000000;
      state_next.sincCnt_reg = DCM_CNT_RESET;
      state_next.iirCnt_reg = DCM_CNT_RESET;
    end
    if (regReq.wrEn) begin
      // A configuration write restarts the averaging window so modes never mix; an IIR config write restarts only the IIR count
      if (regReq.addr == DCM_CFG_OFS) begin
        state_next.cfg_reg = regReq.wrData;
        state_next.acc_reg = 24'sh000000;
        state_next.sincCnt_reg = DCM_CNT_RESET;
        state_next.iirCnt_reg = DCM_CNT_RESET;
      end else if (regReq.addr == DCM_IIR_OFS) begin
        state_next.iirCfg_reg = regReq.wrData;
        state_next.iirCnt_reg = DCM_CNT_RESET;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_reg.cfg_reg <= DCM_CFG_RESET;
      state_reg.iirCfg_reg <= DCM_IIR_RESET;
      state_reg.result_reg <= DCM_RESULT_RESET;
      state_reg.acc_reg <= 24'sh000000;
      state_reg.sincCnt_reg <= DCM_CNT_RESET;
      state_reg.iirCnt_reg <= DCM_CNT_RESET;
      state_reg.rdData_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
    end
  end

  reset_values_a: assert property (@(posedge ref_clk)
    srst |=> (state_reg.cfg_reg == 8'h00 && state_reg.result_reg == 24'h0))
    else $error("config or result not cleared by reset");

  dfield_write_a: assert property (@(posedge ref_clk) disable iff (srst)
    (regReq.wrEn && regReq.addr == DCM_CFG_OFS)
    |=> (dSet == $past(regReq.wrData[4:0])))
    else $error("D field did not take written value");

  disabled_hold_a: assert property (@(posedge ref_clk)
    disable iff (srst)
    (!enable && !$past(srst)) |=> $stable(state_reg.result_reg))
    else $error("result moved while measurement disabled");

  freeze_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    freeze [*2] |-> $stable(state_reg.result_reg))
    else $error("result moved while updates frozen");

  sinc_window_a: assert property (@(posedge ref_clk) disable iff (srst)
    (enable && !iirMode && modValid && !freeze && sincEnd)
    |=> (state_reg.result_reg == $past(sincSum) &&
         state_reg.sincCnt_reg == 21'h0 || $past(regReq.wrEn)))
    else $error("sinc window end did not publish sum");

  iir_follow_a: assert property (@(posedge ref_clk) disable iff (srst)
    (enable && iirMode && modValid && !freeze && !reportLatched)
    |=> (state_reg.result_reg == $past(iirOut)))
    else $error("IIR result not following filter output");

  iir_latch_a: assert property (@(posedge ref_clk) disable iff (srst)
    (enable && iirMode && reportLatched && !iirEnd && !regReq.wrEn)
    |=> $stable(state_reg.result_reg))
    else $error("latched IIR result changed between clears");

  iir_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
    (enable && iirMode && modValid && iirEnd)
    |=> (state_reg.acc_reg == 24'sh0 && state_reg.iirCnt_reg == 21'h0))
    else $error("IIR state not cleared at window end");

  iir_infinite_a: assert property (@(posedge ref_clk) disable iff (srst)
    (enable && iirMode && modValid && avgCode == 5'h00 && !regReq.wrEn)
    |=> (state_reg.acc_reg == $past(iirOut)))
    else $error("IIR accumulator not integrating");

  readback_a: assert property (@(posedge ref_clk) disable iff (srst)
    (regReq.addr == DCM_RES_MID_OFS)
    |=> (regRdData == $past(state_reg.result_reg[15:8])))
    else $error("middle result byte readback wrong");

  hi_readback_a: assert property (@(posedge ref_clk) disable iff (srst)
    (regReq.addr == DCM_RES_HI_OFS)
    |=> (regRdData == $past(state_reg.result_reg[23:16])))
    else $error("high result byte readback wrong");

  lo_readback_a: assert property (@(posedge ref_clk) disable iff (srst)
    (regReq.addr == DCM_RES_LO_OFS)
    |=> (regRdData == $past(state_reg.result_reg[7:0])))
    else $error("low result byte readback wrong");

  cfg_readback_a: assert property (@(posedge ref_clk) disable iff (srst)
    (regReq.addr == DCM_CFG_OFS)
    |=> (regRdData == $past(state_reg.cfg_reg)))
    else $error("configuration readback wrong");

  unused_read_a: assert property (@(posedge ref_clk) disable iff (srst)
    (regReq.addr < DCM_CFG_OFS || regReq.addr > DCM_RES_LO_OFS)
    |=> (regRdData == 8'h00))
    else $error("unmapped address did not read zero");

  ro_write_a: assert property (@(posedge ref_clk) disable iff (srst)
    (regReq.wrEn && regReq.addr >= DCM_RES_HI_OFS)
    |=> ($stable(state_reg.cfg_reg) &&
         $stable(state_reg.iirCfg_reg)))
    else $error("write to result address changed configuration");

  iir_write_a: assert property (@(posedge ref_clk) disable iff (srst)
    (regReq.wrEn && regReq.addr == DCM_IIR_OFS)
    |=> (state_reg.iirCfg_reg == $past(regReq.wrData) &&
         state_reg.iirCnt_reg == DCM_CNT_RESET))
    else $error("IIR configuration write not taken");

  off_clear_a: assert property (@(posedge ref_clk) disable iff (srst)
    !enable
    |=> (state_reg.acc_reg == 24'sh000000 &&
         state_reg.sincCnt_reg == DCM_CNT_RESET &&
         state_reg.iirCnt_reg == DCM_CNT_RESET))
    else $error("filter state not cleared while disabled");

  sinc_count_a: assert property (@(posedge ref_clk) disable iff (srst)
    (enable && !iirMode && modValid && !sincEnd && !regReq.wrEn)
    |=> (state_reg.sincCnt_reg ==
         $past(state_reg.sincCnt_reg) + 21'h000001))
    else $error("sinc sample counter did not advance");

  idle_hold_a: assert property (@(posedge ref_clk) disable iff (srst)
    (enable && !modValid && !regReq.wrEn)
    |=> ($stable(state_reg.acc_reg) && $stable(state_reg.result_reg)))
    else $error("filter moved without a modulator sample");

endmodule : dcm_dc_measure

`default_nettype wire

// ===== inc/dcm_pkg.sv
package dcm_pkg;

  localparam logic [6:0] DCM_CFG_OFS = 7'h66;
  localparam logic [6:0] DCM_IIR_OFS = 7'h67;
  localparam logic [6:0] DCM_RES_HI_OFS = 7'h68;
  localparam logic [6:0] DCM_RES_MID_OFS = 7'h69;
  localparam logic [6:0] DCM_RES_LO_OFS = 7'h6A;

  // Field positions
  localparam int DCM_ENABLE_BIT = 7;
  localparam int DCM_METHOD_BIT = 5;
  localparam int DCM_FREEZE_BIT = 6;
  localparam int DCM_REPORT_BIT = 5;

  localparam logic [7:0] DCM_CFG_RESET = 8'h00;
  localparam logic [7:0] DCM_IIR_RESET = 8'h00;
  localparam logic [23:0] DCM_RESULT_RESET = 24'h000000;
  localparam logic [20:0] DCM_CNT_RESET = 21'h000000;

  // Full-scale input for the IIR path, one modulator bit maps to +/- this
  localparam logic signed [23:0] DCM_IIR_POS = 24'sh3FFFFF;
  localparam logic signed [23:0] DCM_IIR_NEG = 24'shC00001;

  typedef struct packed {
    logic wrEn;
    logic [6:0] addr;
    logic [7:0] wrData;
  } dcm_reg_req_type;

  typedef struct packed {
    logic [7:0] cfg_reg;
    logic [7:0] iirCfg_reg;
    logic [23:0] result_reg;
    logic signed [23:0] acc_reg;
    logic [20:0] sincCnt_reg;
    logic [20:0] iirCnt_reg;
    logic [7:0] rdData_reg;
  } dcm_state_type;

endpackage : dcm_pkg

// ===== tb/dcm_mod_src.sv
`timescale 1ns/1ps
`default_nettype none
// Modulator stand-in: emits cnt samples of level lvl, one every 2 cycles
module dcm_mod_src (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic go,
  input wire logic [7:0] cnt,
  input wire logic lvl,
  output logic modValid,
  output logic modBit,
  output logic busy
);
  logic [7:0] left;
  logic ph;
  logic last;
  // Line shows inverse level between samples, never a stale valid bit
  assign modBit = modValid ? last : ~last;
  assign busy = (left != 8'h00);
  always_ff @(posedge ref_clk) begin
    modValid <= 1'b0;
    if (srst) begin
      left <= 8'h00;
      ph <= 1'b0;
      last <= 1'b0;
    end else if (go) begin
      left <= cnt;
      last <= lvl;
      ph <= 1'b0;
    end else if (busy) begin
      ph <= ~ph;
      if (ph) begin
        modValid <= 1'b1;
        left <= left - 8'h01;
      end
    end
  end
endmodule : dcm_mod_src
`default_nettype wire

// ===== tb/adc_dc_level_measurement_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin miscompares++; \
  $display("ERROR %0t got %h exp %h", $time, a, e); end end
module adc_dc_level_measurement_tb;
  import dcm_pkg::*;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic go = 1'b0;
  logic [7:0] cnt = 8'h00;
  logic lvl = 1'b0;
  logic modValid, modBit, busy;
  dcm_reg_req_type regReq = '0;
  logic [7:0] regRdData, d;
  logic [23:0] r;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  always #2.5 ref_clk = ~ref_clk;
  dcm_mod_src src_u (.ref_clk(ref_clk), .srst(srst), .go(go), .cnt(cnt),
    .lvl(lvl), .modValid(modValid), .modBit(modBit), .busy(busy));
  dcm_dc_measure dut_u (.ref_clk(ref_clk), .srst(srst), .modValid(modValid),
    .modBit(modBit), .regReq(regReq), .regRdData(regRdData));
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge ref_clk) regReq <= '{1'b1, a, v};
    @(posedge ref_clk) regReq.wrEn <= 1'b0;
  endtask : wr
  task automatic rd(input logic [6:0] a, output logic [7:0] v);
    @(posedge ref_clk) regReq <= '{1'b0, a, 8'h00};
    repeat (2) @(posedge ref_clk);
    #1 v = regRdData;
  endtask : rd
  task automatic rdres(output logic [23:0] v);
    rd(DCM_RES_HI_OFS, v[23:16]);
    rd(DCM_RES_MID_OFS, v[15:8]);
    rd(DCM_RES_LO_OFS, v[7:0]);
  endtask : rdres
  task automatic smp(input logic [7:0] n, input logic b);
    int k;
    @(posedge ref_clk) begin
      go <= 1'b1;
      cnt <= n;
      lvl <= b;
    end
    @(posedge ref_clk) go <= 1'b0;
    // Busy seen before the edge's updates; last sample taken at the break
    for (k = 0; k < 600; k++) begin
      @(posedge ref_clk);
      if (!busy) break;
    end
    repeat (4) @(posedge ref_clk);
  endtask : smp
  task automatic end_sim;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    for (int a = 8'h65; a <= 8'h6A; a++) begin
      rd(a[6:0], d);
      `CHK(d, 8'h00)
    end
    wr(DCM_RES_HI_OFS, 8'hAA);
    rd(DCM_RES_HI_OFS, d);
    `CHK(d, 8'h00)
    // Sinc, D=2: four full-scale samples sum to +4 or -4
    wr(DCM_CFG_OFS, 8'h82);
    rd(DCM_CFG_OFS, d);
    `CHK(d, 8'h82)
    smp(8'd4, 1'b1);
    rdres(r);
    `CHK(r, 24'h000004)
    smp(8'd4, 1'b0);
    rdres(r);
    `CHK(r, 24'hFFFFFC)
    wr(DCM_IIR_OFS, 8'h40);
    smp(8'd4, 1'b1);
    rdres(r);
    `CHK(r, 24'hFFFFFC)
    wr(DCM_IIR_OFS, 8'h00);
    smp(8'd4, 1'b1);
    rdres(r);
    `CHK(r, 24'h000004)
    wr(DCM_CFG_OFS, 8'h02);
    smp(8'd4, 1'b0);
    rdres(r);
    `CHK(r, 24'h000004)
    // IIR, D=1, infinite average: one step from zero halves full scale
    wr(DCM_CFG_OFS, 8'hA1);
    smp(8'd1, 1'b1);
    rdres(r);
    `CHK(r, 24'h1FFFFF)
    // Clear every 2 samples, latched value is the second step
    wr(DCM_IIR_OFS, 8'h21);
    wr(DCM_CFG_OFS, 8'hA1);
    smp(8'd4, 1'b1);
    rdres(r);
    `CHK(r, 24'h2FFFFF)
    rd(DCM_IIR_OFS, d);
    `CHK(d, 8'h21)
    // Reset in mid-run clears the result and the configuration
    @(posedge ref_clk) srst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    rdres(r);
    `CHK(r, 24'h000000)
    rd(DCM_CFG_OFS, d);
    `CHK(d, 8'h00)
    end_sim();
  end
endmodule : adc_dc_level_measurement_tb
`default_nettype wire
